//--- src/asq_consts.svh
// register offsets, field positions, reset values and timing counts for the converter sequencer
`ifndef ASQ_CONSTS_SVH
`define ASQ_CONSTS_SVH

`define ASQ_OFF_CTRL_A      4'h0
`define ASQ_OFF_CTRL_B      4'h4
`define ASQ_OFF_CTRL_C      4'h8
`define ASQ_OFF_DMA_SIZE    4'hC

`define ASQ_A_ON            15
`define ASQ_A_ORDER         12
`define ASQ_A_WIDE          10
`define ASQ_A_TRIG_HI       7
`define ASQ_A_TRIG_LO       5
`define ASQ_A_PAR           3
`define ASQ_A_AUTO          2
`define ASQ_A_ACQ           1
`define ASQ_A_DONE          0
`define ASQ_A_WMASK         16'h94EE

`define ASQ_B_CHANNEL_COUNT_SELECT_HI       9
`define ASQ_B_CHANNEL_COUNT_SELECT_LO       8
`define ASQ_B_RATE_HI       5
`define ASQ_B_RATE_LO       2
`define ASQ_B_WMASK         16'h033C

`define ASQ_C_RC            15
`define ASQ_C_WMASK         16'h9FFF
`define ASQ_D_WMASK         16'h0007

`define ASQ_RESET_VAL       16'h0000

`define ASQ_TRIG_MANUAL     3'h0
`define ASQ_TRIG_T3         3'h2
`define ASQ_TRIG_T5         3'h4
`define ASQ_TRIG_AUTO       3'h7

`define ASQ_DIV_MAX         8'h3F
`define ASQ_CONV_TADS       5'h0E
`endif

//--- src/asq_pkg.sv
// types for the converter sequencer
package asq_pkg;
  typedef enum logic [1:0]
  {
    ST_OFF  = 2'b00,
    ST_ACQ  = 2'b01,
    ST_CONV = 2'b10,
    ST_IDLE = 2'b11
  } asq_state_t;

  typedef struct packed
  {
    logic        req;
    logic [10:0] addr;
  } asq_dma_t;
endpackage

//--- src/asq_sequencer.sv
// converter sequencer with wishbone registers, conversion clock and dma address generation
`timescale 1ns/1ps
`include "asq_consts.svh"

// How it works
// - a dma request pulses each time the conversion flag is set
// - address advances or flag raises once every rate-plus-one conversions
// - order bit set gives sequential address, else input index times buffer size
// - buffer size field reserves two to the power of code words per input
// - trigger 100 uses timer 5 compare, 010 uses timer 3 compare
// - non-manual trigger: hardware clears acquire bit on the trigger
// - auto restart sets acquire bit after every conversion
// - done bit is set when a conversion cycle finishes
// - software may only clear done; clearing leaves conversion running
// - done bit clears itself when a new conversion starts
// - parallel hold samples channels together, else one after another
// - in wide mode the parallel hold bit reads zero
// - clock source bit picks the rc clock when set
// - divider is ignored while the rc clock is selected
// - resolution bit forces single-channel operation when set, else the channel count field picks one, two or four channels
module asq_sequencer
#(
  parameter int CONV_TADS = 14
)
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESET_N,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [1:0]  i_wb_sel,
  input  wire logic [15:0] i_wb_dat,
  output logic      [15:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_t3_cmp,
  input  wire logic        i_t5_cmp,
  input  wire logic        i_ext_trig,
  input  wire logic        i_rc_tick,
  input  wire logic [3:0]  i_input_idx,
  output logic             o_dma_req,
  output logic      [10:0] o_dma_addr,
  output logic             o_irq_flag,
  output logic      [3:0]  o_hold_track,
  output logic             o_convert
);

  ////////////////////////////////////////////////////////////////////////
  logic [15:0] ctl_a_r, ctl_a_nxt, ctl_b_r, ctl_b_nxt, ctl_c_r, ctl_c_nxt, ctl_d_r, ctl_d_nxt;
  logic [15:0] rd_nxt, wmask, wdat;
  logic        ack_nxt;
  logic        wr_go;
  logic        hw_acq_set, hw_acq_clr, hw_done_set, hw_done_clr;
  logic        wide;
  logic [2:0]  trig;

  assign wide  = ctl_a_r[`ASQ_A_WIDE];
  assign trig  = ctl_a_r[`ASQ_A_TRIG_HI:`ASQ_A_TRIG_LO];
  assign wr_go = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack; // lands on the edge that ack is seen
  assign wmask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

  always_comb
  begin
    ctl_a_nxt = ctl_a_r;
    ctl_b_nxt = ctl_b_r;
    ctl_c_nxt = ctl_c_r;
    ctl_d_nxt = ctl_d_r;
    wdat      = i_wb_dat;
    ack_nxt   = i_wb_cyc && i_wb_stb && !o_wb_ack;
    if (wr_go)
    begin
      unique case (i_wb_adr)
        `ASQ_OFF_CTRL_A:
        begin
          // done bit: a written one is dropped, zero clears it
          wdat[`ASQ_A_DONE] = i_wb_dat[`ASQ_A_DONE] & ctl_a_r[`ASQ_A_DONE];
          ctl_a_nxt = (ctl_a_r & ~(wmask & (`ASQ_A_WMASK | 16'h0001))) |
                      (wdat & wmask & (`ASQ_A_WMASK | 16'h0001));
        end
        `ASQ_OFF_CTRL_B:   ctl_b_nxt = (ctl_b_r & ~(wmask & `ASQ_B_WMASK)) | (i_wb_dat & wmask & `ASQ_B_WMASK);
        `ASQ_OFF_CTRL_C:   ctl_c_nxt = (ctl_c_r & ~(wmask & `ASQ_C_WMASK)) | (i_wb_dat & wmask & `ASQ_C_WMASK);
        `ASQ_OFF_DMA_SIZE: ctl_d_nxt = (ctl_d_r & ~(wmask & `ASQ_D_WMASK)) | (i_wb_dat & wmask & `ASQ_D_WMASK);
        default:           ctl_d_nxt = ctl_d_r;
      endcase
    end
    // hardware events win over software writes
    if (hw_acq_clr)
      ctl_a_nxt[`ASQ_A_ACQ] = 1'b0;
    if (hw_acq_set)
      ctl_a_nxt[`ASQ_A_ACQ] = 1'b1;
    if (hw_done_clr)
      ctl_a_nxt[`ASQ_A_DONE] = 1'b0;
    if (hw_done_set)
      ctl_a_nxt[`ASQ_A_DONE] = 1'b1;
    if (!ctl_a_nxt[`ASQ_A_ON])
      ctl_a_nxt[`ASQ_A_ACQ] = 1'b0;
  end

  always_comb
  begin
    rd_nxt = 16'h0000;
    unique case (i_wb_adr)
      `ASQ_OFF_CTRL_A:
      begin
        rd_nxt = ctl_a_r;
        if (wide)
          rd_nxt[`ASQ_A_PAR] = 1'b0;
      end
      `ASQ_OFF_CTRL_B:
      begin
        rd_nxt = ctl_b_r;
        if (wide)
          rd_nxt[`ASQ_B_CHANNEL_COUNT_SELECT_HI:`ASQ_B_CHANNEL_COUNT_SELECT_LO] = 2'b00;
      end
      `ASQ_OFF_CTRL_C:   rd_nxt = ctl_c_r;
      `ASQ_OFF_DMA_SIZE: rd_nxt = ctl_d_r;
      default:           rd_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      ctl_a_r  <= `ASQ_RESET_VAL;
      ctl_b_r  <= `ASQ_RESET_VAL;
      ctl_c_r  <= `ASQ_RESET_VAL;
      ctl_d_r  <= `ASQ_RESET_VAL;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 16'h0000;
    end
    else
    begin
      ctl_a_r  <= ctl_a_nxt;
      ctl_b_r  <= ctl_b_nxt;
      ctl_c_r  <= ctl_c_nxt;
      ctl_d_r  <= ctl_d_nxt;
      o_wb_ack <= ack_nxt;
      o_wb_dat <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion clock tick
  logic [7:0] div_cnt_r, div_cnt_nxt, div_lim;
  logic       tad_tick;

  always_comb
  begin
    div_lim = (ctl_c_r[7:0] > `ASQ_DIV_MAX) ? `ASQ_DIV_MAX : ctl_c_r[7:0];
    div_cnt_nxt = (div_cnt_r >= div_lim) ? 8'h00 : div_cnt_r + 8'h01;
  end

  // rc source bypasses the divider entirely
  assign tad_tick = ctl_c_r[`ASQ_C_RC] ? i_rc_tick : (div_cnt_r >= div_lim);

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      div_cnt_r <= 8'h00;
    else
      div_cnt_r <= div_cnt_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // sample and convert sequence
  asq_pkg::asq_state_t st_r, st_nxt;
  logic [4:0] tcnt_r, tcnt_nxt;
  logic [1:0] chan_r, chan_nxt, nchan;
  logic [3:0] grp_r, grp_nxt;
  logic [6:0] seq_r, seq_nxt;
  logic       trig_hit, par, conv_end, flag_nxt;
  logic [3:0] track_nxt;

  always_comb
  begin
    unique case (trig)
      `ASQ_TRIG_T3:   trig_hit = i_t3_cmp;
      `ASQ_TRIG_T5:   trig_hit = i_t5_cmp;
      3'h1:           trig_hit = i_ext_trig;
      `ASQ_TRIG_AUTO: trig_hit = tad_tick && (tcnt_r >= ctl_c_r[12:8]);
      default:        trig_hit = 1'b0;
    endcase
  end

  assign nchan = wide ? 2'd0 : (ctl_b_r[`ASQ_B_CHANNEL_COUNT_SELECT_HI] ? 2'd3 : {1'b0, ctl_b_r[`ASQ_B_CHANNEL_COUNT_SELECT_LO]});
  assign par   = ctl_a_r[`ASQ_A_PAR] && !wide;

  always_comb
  begin
    st_nxt      = st_r;
    tcnt_nxt    = tcnt_r;
    chan_nxt    = chan_r;
    grp_nxt     = grp_r;
    seq_nxt     = seq_r;
    hw_acq_set  = 1'b0;
    hw_acq_clr  = 1'b0;
    hw_done_set = 1'b0;
    hw_done_clr = 1'b0;
    conv_end    = 1'b0;
    flag_nxt    = 1'b0;
    track_nxt   = 4'h0;
    unique case (st_r)
      asq_pkg::ST_OFF:
      begin
        tcnt_nxt = 5'h00;
        chan_nxt = 2'd0;
        grp_nxt  = 4'h0;
        seq_nxt  = 7'h00;
        if (ctl_a_r[`ASQ_A_ON])
          st_nxt = asq_pkg::ST_IDLE;
      end
      asq_pkg::ST_IDLE:
        if (ctl_a_r[`ASQ_A_ACQ])
        begin
          st_nxt   = asq_pkg::ST_ACQ;
          tcnt_nxt = 5'h00;
        end
      asq_pkg::ST_ACQ:
      begin
        // parallel: all used holds track; sequential: only the current one
        track_nxt = par ? ((nchan == 2'd1) ? 4'h3 : (nchan == 2'd3) ? 4'hF : 4'h1)
                        : (4'h1 << chan_r);
        if (tad_tick && tcnt_r != 5'h1F)
          tcnt_nxt = tcnt_r + 5'h01;
        if (!ctl_a_r[`ASQ_A_ACQ] || (trig != `ASQ_TRIG_MANUAL && trig_hit))
        begin
          hw_acq_clr  = 1'b1;
          hw_done_clr = 1'b1;
          st_nxt      = asq_pkg::ST_CONV;
          tcnt_nxt    = 5'h00;
        end
      end
      asq_pkg::ST_CONV:
      begin
        if (tad_tick)
          tcnt_nxt = tcnt_r + 5'h01;
        if (tad_tick && tcnt_r == 5'(CONV_TADS - 1))
        begin
          conv_end    = 1'b1;
          hw_done_set = 1'b1;
          chan_nxt    = (chan_r == nchan) ? 2'd0 : chan_r + 2'd1;
          tcnt_nxt    = 5'h00;
          if (grp_r == ctl_b_r[`ASQ_B_RATE_HI:`ASQ_B_RATE_LO])
          begin
            grp_nxt  = 4'h0;
            seq_nxt  = seq_r + 7'h01;
            flag_nxt = 1'b1;
          end
          else
            grp_nxt = grp_r + 4'h1;
          hw_acq_set = ctl_a_r[`ASQ_A_AUTO];
          st_nxt     = ctl_a_r[`ASQ_A_AUTO] ? asq_pkg::ST_ACQ : asq_pkg::ST_IDLE;
        end
      end
    endcase
    if (!ctl_a_r[`ASQ_A_ON])
      st_nxt = asq_pkg::ST_OFF;
  end

  ////////////////////////////////////////////////////////////////////////
  // dma address
  logic [10:0] addr_nxt, sg_addr;
  assign sg_addr = 11'({i_input_idx, 7'h00} >> (3'd7 - ctl_d_r[2:0])) + 11'(seq_r & ((7'h01 << ctl_d_r[2:0]) - 7'h01));

  always_comb
  begin
    addr_nxt = o_dma_addr;
    if (flag_nxt)
      addr_nxt = ctl_a_r[`ASQ_A_ORDER] ? {4'h0, seq_r} : sg_addr;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      st_r         <= asq_pkg::ST_OFF;
      tcnt_r       <= 5'h00;
      chan_r       <= 2'd0;
      grp_r        <= 4'h0;
      seq_r        <= 7'h00;
      o_dma_req    <= 1'b0;
      o_irq_flag   <= 1'b0;
      o_dma_addr   <= 11'h000;
      o_hold_track <= 4'h0;
      o_convert    <= 1'b0;
    end
    else
    begin
      st_r         <= st_nxt;
      tcnt_r       <= tcnt_nxt;
      chan_r       <= chan_nxt;
      grp_r        <= grp_nxt;
      seq_r        <= seq_nxt;
      o_dma_req    <= flag_nxt;
      o_irq_flag   <= flag_nxt;
      o_dma_addr   <= addr_nxt;
      o_hold_track <= track_nxt;
      o_convert    <= (st_nxt == asq_pkg::ST_CONV);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_req_flag;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      o_dma_req |-> o_irq_flag && $past(st_r) == asq_pkg::ST_CONV;
  endproperty
  a_req_flag: assert property (p_req_flag) else $error("dma request without conversion end");

  property p_done_set;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      conv_end |=> ctl_a_r[`ASQ_A_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set at conversion end");

  property p_done_clr;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (st_r == asq_pkg::ST_ACQ && st_nxt == asq_pkg::ST_CONV) |=> !ctl_a_r[`ASQ_A_DONE];
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done not cleared at conversion start");

  property p_auto;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (conv_end && ctl_a_r[`ASQ_A_AUTO] && ctl_a_r[`ASQ_A_ON]) |=> ctl_a_r[`ASQ_A_ACQ] && st_r == asq_pkg::ST_ACQ;
  endproperty
  a_auto: assert property (p_auto) else $error("auto restart did not resume sampling");

  property p_trig;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (st_r == asq_pkg::ST_ACQ && trig != `ASQ_TRIG_MANUAL && trig_hit && ctl_a_r[`ASQ_A_ON])
        |=> !ctl_a_r[`ASQ_A_ACQ] ##1 o_convert;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not end sampling");

  property p_wide_par;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (wide && i_wb_cyc && i_wb_stb && !i_wb_we && i_wb_adr == `ASQ_OFF_CTRL_A) |=> !o_wb_dat[`ASQ_A_PAR];
  endproperty
  a_wide_par: assert property (p_wide_par) else $error("parallel bit visible in wide mode");

  property p_rate;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      grp_r <= ctl_b_r[`ASQ_B_RATE_HI:`ASQ_B_RATE_LO] || st_r != asq_pkg::ST_CONV || $changed(ctl_b_r);
  endproperty
  a_rate: assert property (p_rate) else $error("group count passed rate");

  property p_rc;
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      ctl_c_r[`ASQ_C_RC] |-> tad_tick == i_rc_tick;
  endproperty
  a_rc: assert property (p_rc) else $error("rc clock not used");

endmodule

//--- verif/asq_dma_model.sv
// dma controller model that logs every transfer request of the sequencer
`timescale 1ns/1ps
module asq_dma_model
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire asq_pkg::asq_dma_t i_dma,
  input  wire logic             i_irq
);
  int          n_req;
  int          n_irq;
  logic [10:0] addr_q [$];

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      n_req <= 0;
      n_irq <= 0;
      addr_q.delete();
    end
    else
    begin
      // one transfer per request pulse, at the address shown with it
      if (i_dma.req === 1'b1)
      begin
        n_req <= n_req + 1;
        addr_q.push_back(i_dma.addr);
      end
      if (i_irq === 1'b1)
        n_irq <= n_irq + 1;
    end
  end
endmodule

//--- verif/tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_top;
  localparam int TADS = 4;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic t3 = 0, t5 = 0, ext = 0, rc = 0, rc_en = 0;
  logic [3:0] adr = 0, idx = 0, hold;
  logic [1:0] sel = 2'b11;
  logic [15:0] wdat = 0, rdat, q;
  logic ack, dreq, irq, conv;
  logic [10:0] daddr;
  asq_pkg::asq_dma_t dma;
  int n_errors = 0, num_checks = 0, cyc_cnt = 0, r, s, k;
  logic [10:0] exp_q [$];
  logic [2:0] codes [4] = '{3'h2, 3'h4, 3'h1, 3'h7};
  logic [2:0] pins [4] = '{3'b100, 3'b010, 3'b001, 3'b000};

  assign dma.req = dreq;
  assign dma.addr = daddr;
  always #12.5 clk = ~clk;
  always @(posedge clk) rc <= rc_en & 1'($urandom % 2);

  asq_sequencer #(.CONV_TADS(TADS)) u_dut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_t3_cmp(t3), .i_t5_cmp(t5), .i_ext_trig(ext), .i_rc_tick(rc),
    .i_input_idx(idx), .o_dma_req(dreq), .o_dma_addr(daddr), .o_irq_flag(irq),
    .o_hold_track(hold), .o_convert(conv));
  asq_dma_model u_dma (.i_clk(clk), .i_rst_n(rst_n), .i_dma(dma), .i_irq(irq));

  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    chk("ack", ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [3:0] a, input logic [15:0] exp);
    wb(1'b0, a, 16'h0000);
    chk(what, q, exp);
  endtask

  task automatic wait_conv(input logic lvl);
    int n;
    n = 0;
    while (conv !== lvl && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    chk("convert level", conv, lvl);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // software starts sampling, then ends it to convert
  task automatic manual_conv(input logic [15:0] a);
    wb(1'b1, 4'h0, a | 16'h0002);
    wb(1'b1, 4'h0, a);
    wait_conv(1'b1);
    wb(1'b0, 4'h0, 16'h0000);
    chk("done at start", q[0], 1'b0);
    wb(1'b1, 4'h0, a);
    wait_conv(1'b0);
    repeat (2) @(posedge clk);
    rd("done set", 4'h0, a | 16'h0001);
    wb(1'b1, 4'h0, a);
    rd("done cleared", 4'h0, a);
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hec60));
    do_reset();
    foreach (pins[i])
      rd("reset value", 4'(i * 4), 16'h0000);
    rd("unmapped", 4'h2, 16'h0000);
    wb(1'b1, 4'h4, 16'hFFFF);
    rd("control_b", 4'h4, 16'h033C);
    wb(1'b1, 4'h8, 16'hFFFF);
    rd("control_c", 4'h8, 16'h9FFF);
    wb(1'b1, 4'hC, 16'hFFFF);
    rd("buffer size", 4'hC, 16'h0007);
    wb(1'b1, 4'h0, 16'h0408);
    rd("wide parallel", 4'h0, 16'h0400);
    rd("wide count", 4'h4, 16'h003C);
    $display("test registers done");

    do_reset();
    r = $urandom % 4;
    wb(1'b1, 4'h4, 16'(r) << 2);
    wb(1'b1, 4'h8, 16'h0003);
    for (k = 0; k < 2 * (r + 1); k++)
      manual_conv(16'h9000);
    chk("requests", 16'(u_dma.n_req), 16'h0002);
    chk("irq pulses", 16'(u_dma.n_irq), 16'h0002);
    foreach (u_dma.addr_q[i])
      chk("seq addr", 16'(u_dma.addr_q[i]), 16'(i));
    $display("test sequential done");

    foreach (pins[j])
    begin
      do_reset();
      s = (j == 0) ? 7 : $urandom % 7;
      exp_q.delete();
      wb(1'b1, 4'h8, 16'h0003);
      wb(1'b1, 4'hC, 16'(s));
      for (k = 0; k < 3; k++)
      begin
        idx <= 4'($urandom % 16);
        @(posedge clk);
        exp_q.push_back(11'((idx << s) + (k % (1 << s))));
        manual_conv(16'h8000);
      end
      foreach (exp_q[i])
        chk("gather addr", 16'(u_dma.addr_q[i]), 16'(exp_q[i]));
    end
    $display("test scatter done");

    foreach (codes[j])
    begin
      do_reset();
      wb(1'b1, 4'h8, 16'h0203);
      wb(1'b1, 4'h0, 16'h8004 | (16'(codes[j]) << 5));
      wb(1'b1, 4'h0, 16'h8006 | (16'(codes[j]) << 5));
      if (codes[j] != 3'h7)
      begin
        // let sampling begin so the wrong pulse meets a live trigger decode
        repeat (2) @(posedge clk);
        {t3, t5, ext} <= ~pins[j];
        @(posedge clk);
        {t3, t5, ext} <= 3'b000;
        repeat (4) @(posedge clk);
        chk("wrong trigger", conv, 1'b0);
        {t3, t5, ext} <= pins[j];
        @(posedge clk);
        {t3, t5, ext} <= 3'b000;
      end
      wait_conv(1'b1);
      wb(1'b0, 4'h0, 16'h0000);
      chk("acquire cleared", q[1], 1'b0);
      wait_conv(1'b0);
      @(posedge clk);
      wb(1'b0, 4'h0, 16'h0000);
      chk("acquire restart", q[1:0], 2'b11);
    end
    $display("test triggers done");

    for (k = 0; k < 3; k++)
    begin
      do_reset();
      wb(1'b1, 4'h4, 16'(k) << 8);
      wb(1'b1, 4'h0, (k == 0) ? 16'h8002 : 16'h800A);
      repeat (4) @(posedge clk);
      chk("hold tracking", hold, (k == 0) ? 4'h1 : (k == 1) ? 4'h3 : 4'hF);
    end
    $display("test parallel done");

    do_reset();
    wb(1'b1, 4'h8, 16'h8000);
    wb(1'b1, 4'h0, 16'h8002);
    wb(1'b1, 4'h0, 16'h8000);
    repeat (40) @(posedge clk);
    chk("no rc ticks", 16'(u_dma.n_req), 16'h0000);
    rc_en <= 1'b1;
    for (k = 0; k < 200 && u_dma.n_req < 1; k++)
      @(posedge clk);
    chk("rc conversion", 16'(u_dma.n_req), 16'h0001);
    $display("test rc clock done");
    conclude();
  end

  always @(posedge clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000)
    begin
      n_errors++;
      conclude();
    end
  end
endmodule
